/* File: tsp_core.sv */
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module tsp_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  tsp_pkg::tsp_state_t st_r;
  tsp_pkg::tsp_state_t st_nxt;
  logic a_vld_r, a_wr_r, mdone_r, a_mem, busy;
  logic [8:0] a_addr_r;
  logic [31:0] rd_r, mem_rdata, e_wdata, m_wdata, fin_flags, stat;
  logic [31:0] flags_r, cr0_r, desc_r, ndesc_r, ctx_r, op_r, nflg_r, io_r;
  logic [15:0] tr_r, base_r, limit_r, mapb_r, nsel_r;
  logic [5:0] e_addr, m_addr;
  logic e_we, m_we;
  logic [16:0] io_off, io_off1, ba0, ba1;
  logic [7:0] b0_r, b1, exc_vec_r;
  logic [15:0] win;
  logic [3:0] mask, mark_r;
  logic exc_vld_r, io_done_r, io_ok_r, nt_sav_r, deny, tbit;
  logic op_go, io_go, sw_req, busy_hit, sw_go, int_plain, interrupt_return_op_plain, esc_flt;
  logic io_priv, nt, ts, op_link, op_interrupt_return_op;

  function automatic logic wr_at(input logic [8:0] off, input logic v, input logic w,
                                 input logic [8:0] a);
    return v && w && a == off;
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] l);
    logic [31:0] s;
    s = w >> {l, 3'b000};
    return s[7:0];
  endfunction

  assign a_mem = a_addr_r[tsp_pkg::MEM_BIT];
  assign busy = st_r != tsp_pkg::ST_IDLE;
  assign nt = flags_r[tsp_pkg::FLG_NT];
  assign ts = cr0_r[tsp_pkg::CR0_TS];
  assign hresp = 1'b0;
  // Reads take one wait state so a read right after a write sees the new value
  assign hreadyout = !(a_vld_r && ((!a_wr_r && !mdone_r) || (a_mem && busy)));
  assign hrdata = a_mem ? mem_rdata : rd_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_vld_r <= 1'b0;
      a_wr_r <= 1'b0;
      a_addr_r <= 9'h000;
    end else if (hready) begin
      a_vld_r <= hsel && htrans[1];
      a_wr_r <= hwrite;
      a_addr_r <= haddr[8:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mdone_r <= 1'b0;
    end else begin
      mdone_r <= a_vld_r && !a_wr_r && !mdone_r && !(a_mem && busy);
    end
  end

  // Commands are refused while the engine runs
  assign op_go = !a_mem && !busy && wr_at(tsp_pkg::OFF_OP, a_vld_r, a_wr_r, a_addr_r);
  assign io_go = !a_mem && !busy && wr_at(tsp_pkg::OFF_IO, a_vld_r, a_wr_r, a_addr_r);
  assign sw_req = op_go && ((hwdata[3] && (hwdata[2:0] == tsp_pkg::OPC_JMP ||
                  hwdata[2:0] == tsp_pkg::OPC_CALL || hwdata[2:0] == tsp_pkg::OPC_INT)) ||
                  (hwdata[2:0] == tsp_pkg::OPC_INTERRUPT_RETURN_OP && nt));
  assign busy_hit = sw_req && hwdata[2:0] != tsp_pkg::OPC_INTERRUPT_RETURN_OP &&
                    hwdata[7:4] == tsp_pkg::TYPE_BUSY;
  assign sw_go = sw_req && !busy_hit;
  assign int_plain = op_go && hwdata[2:0] == tsp_pkg::OPC_INT && !hwdata[3];
  assign interrupt_return_op_plain = op_go && hwdata[2:0] == tsp_pkg::OPC_INTERRUPT_RETURN_OP && !nt;
  assign esc_flt = op_go && hwdata[2:0] == tsp_pkg::OPC_ESC && ts;
  assign io_priv = hwdata[19:18] <= flags_r[tsp_pkg::FLG_IO_PRIVILEGE_THRESHOLD_LO +: 2];
  assign op_link = op_r[2:0] == tsp_pkg::OPC_CALL || op_r[2:0] == tsp_pkg::OPC_INT;
  assign op_interrupt_return_op = op_r[2:0] == tsp_pkg::OPC_INTERRUPT_RETURN_OP;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      tsp_pkg::ST_IDLE: begin
        if (sw_go) begin
          st_nxt = tsp_pkg::ST_SV_FLG;
        end else if (io_go && !io_priv) begin
          st_nxt = tsp_pkg::ST_IOM;
        end
      end
      tsp_pkg::ST_SV_FLG: st_nxt = tsp_pkg::ST_SV_CTX;
      tsp_pkg::ST_SV_CTX: st_nxt = tsp_pkg::ST_RD_LINK;
      tsp_pkg::ST_RD_LINK: st_nxt = tsp_pkg::ST_WR_LINK;
      tsp_pkg::ST_WR_LINK: st_nxt = tsp_pkg::ST_LD_FLG;
      tsp_pkg::ST_LD_FLG: st_nxt = tsp_pkg::ST_LD_CTX;
      tsp_pkg::ST_LD_CTX: st_nxt = tsp_pkg::ST_LD_MAP;
      tsp_pkg::ST_LD_MAP: st_nxt = tsp_pkg::ST_LD_WAIT;
      tsp_pkg::ST_LD_WAIT: st_nxt = tsp_pkg::ST_FIN;
      tsp_pkg::ST_IOM: st_nxt = tsp_pkg::ST_IOB;
      tsp_pkg::ST_IOB: st_nxt = tsp_pkg::ST_IO0;
      tsp_pkg::ST_IO0: st_nxt = tsp_pkg::ST_IO1;
      tsp_pkg::ST_IO1: st_nxt = tsp_pkg::ST_IO2;
      default: st_nxt = tsp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= tsp_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Map addressing relative to the current task block
  assign io_off = {1'b0, mapb_r} + {4'h0, io_r[15:3]};
  assign io_off1 = io_off + 17'h00001;
  assign ba0 = {1'b0, base_r} + io_off;
  assign ba1 = {1'b0, base_r} + io_off1;

  // Only flags and context travel; coprocessor state is left to the handler
  always_comb begin
    e_we = 1'b0;
    e_wdata = tsp_pkg::RST_ZERO;
    e_addr = 6'h00;
    case (st_r)
      tsp_pkg::ST_SV_FLG: begin
        e_we = 1'b1;
        e_addr = 6'(({1'b0, base_r} + tsp_pkg::TSB_FLG) >> 2);
        e_wdata = flags_r;
      end
      tsp_pkg::ST_SV_CTX: begin
        e_we = 1'b1;
        e_addr = 6'(({1'b0, base_r} + tsp_pkg::TSB_CTX) >> 2);
        e_wdata = ctx_r;
      end
      tsp_pkg::ST_RD_LINK: e_addr = 6'(({1'b0, base_r} + tsp_pkg::TSB_LINK) >> 2);
      tsp_pkg::ST_WR_LINK: begin
        e_we = op_link;
        e_addr = 6'(({1'b0, ndesc_r[15:0]} + tsp_pkg::TSB_LINK) >> 2);
        e_wdata = {16'h0000, tr_r};
      end
      tsp_pkg::ST_LD_FLG: e_addr = 6'(({1'b0, ndesc_r[15:0]} + tsp_pkg::TSB_FLG) >> 2);
      tsp_pkg::ST_LD_CTX: e_addr = 6'(({1'b0, ndesc_r[15:0]} + tsp_pkg::TSB_CTX) >> 2);
      tsp_pkg::ST_LD_MAP, tsp_pkg::ST_LD_WAIT:
        e_addr = 6'(({1'b0, ndesc_r[15:0]} + tsp_pkg::TSB_MAP) >> 2);
      tsp_pkg::ST_IOM: e_addr = 6'(({1'b0, base_r} + tsp_pkg::TSB_MAP) >> 2);
      tsp_pkg::ST_IO0: e_addr = ba0[7:2];
      tsp_pkg::ST_IO1: e_addr = ba1[7:2];
      default: ;
    endcase
  end

  assign m_addr = busy ? e_addr : a_addr_r[7:2];
  assign m_we = busy ? e_we : (a_vld_r && a_wr_r && a_mem);
  assign m_wdata = busy ? e_wdata : hwdata;

  tsp_mem u_mem (
    .hclk(hclk),
    .addr(m_addr),
    .we(m_we),
    .wdata(m_wdata),
    .rdata_r(mem_rdata)
  );

  // Missing map bytes read as all ones
  assign b1 = (io_off1 > {1'b0, limit_r}) ? 8'hFF : byte_of(mem_rdata, ba1[1:0]);
  assign win = {b1, b0_r} >> io_r[2:0];
  assign mask = (io_r[17:16] == 2'h0) ? 4'h1 : (io_r[17:16] == 2'h1) ? 4'h3 : 4'hF;
  assign deny = |(win[3:0] & mask);
  assign tbit = mem_rdata[tsp_pkg::TSB_TBIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mapb_r <= 16'h0000;
      b0_r <= 8'h00;
    end else begin
      if (st_r == tsp_pkg::ST_IOB) begin
        mapb_r <= mem_rdata[15:0];
      end
      if (st_r == tsp_pkg::ST_IO1) begin
        b0_r <= (io_off > {1'b0, limit_r}) ? 8'hFF : byte_of(mem_rdata, ba0[1:0]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_r <= tsp_pkg::RST_ZERO;
      ndesc_r <= tsp_pkg::RST_ZERO;
      nsel_r <= 16'h0000;
      nflg_r <= tsp_pkg::RST_ZERO;
    end else begin
      if (op_go) begin
        op_r <= hwdata;
        ndesc_r <= desc_r;
        nsel_r <= hwdata[31:16];
      end
      if (st_r == tsp_pkg::ST_WR_LINK && op_interrupt_return_op) begin
        nsel_r <= mem_rdata[15:0];
      end
      if (st_r == tsp_pkg::ST_LD_CTX) begin
        nflg_r <= mem_rdata;
      end
    end
  end

  always_comb begin
    fin_flags = nflg_r;
    fin_flags[tsp_pkg::FLG_NT] = nflg_r[tsp_pkg::FLG_NT] | op_link;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= tsp_pkg::RST_FLAGS;
      nt_sav_r <= 1'b0;
    end else begin
      if (wr_at(tsp_pkg::OFF_FLG, a_vld_r, a_wr_r, a_addr_r) && !a_mem && !busy) begin
        flags_r <= hwdata;
      end else if (st_r == tsp_pkg::ST_FIN) begin
        flags_r <= fin_flags;
      end else if (int_plain) begin
        flags_r[tsp_pkg::FLG_NT] <= 1'b0;
      end else if (interrupt_return_op_plain) begin
        flags_r[tsp_pkg::FLG_NT] <= nt_sav_r;
      end
      if (int_plain) begin
        nt_sav_r <= nt;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctx_r <= tsp_pkg::RST_ZERO;
      cr0_r <= tsp_pkg::RST_ZERO;
      desc_r <= tsp_pkg::RST_ZERO;
    end else begin
      if (wr_at(tsp_pkg::OFF_CTX, a_vld_r, a_wr_r, a_addr_r) && !a_mem && !busy) begin
        ctx_r <= hwdata;
      end else if (st_r == tsp_pkg::ST_LD_MAP) begin
        ctx_r <= mem_rdata;
      end
      if (wr_at(tsp_pkg::OFF_DESC, a_vld_r, a_wr_r, a_addr_r) && !a_mem) begin
        desc_r <= hwdata;
      end
      if (wr_at(tsp_pkg::OFF_CR0, a_vld_r, a_wr_r, a_addr_r) && !a_mem) begin
        cr0_r <= hwdata;
      end
      if (st_r == tsp_pkg::ST_FIN) begin
        cr0_r[tsp_pkg::CR0_TS] <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tr_r <= 16'h0000;
      base_r <= 16'h0000;
      limit_r <= 16'h0000;
      mark_r <= tsp_pkg::TYPE_AVAIL;
    end else begin
      if (wr_at(tsp_pkg::OFF_TR, a_vld_r, a_wr_r, a_addr_r) && !a_mem && !busy) begin
        tr_r <= hwdata[15:0];
        base_r <= desc_r[15:0];
        limit_r <= desc_r[31:16];
      end else if (st_r == tsp_pkg::ST_FIN) begin
        tr_r <= nsel_r;
        base_r <= ndesc_r[15:0];
        limit_r <= ndesc_r[31:16];
      end
      if (sw_go && hwdata[2:0] != tsp_pkg::OPC_INTERRUPT_RETURN_OP) begin
        mark_r <= tsp_pkg::TYPE_BUSY;
      end
    end
  end

  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_vld_r <= 1'b0;
      exc_vec_r <= 8'h00;
    end else begin
      if (wr_at(tsp_pkg::OFF_STAT, a_vld_r, a_wr_r, a_addr_r) && !a_mem && hwdata[0]) begin
        exc_vld_r <= 1'b0;
      end
      if (busy_hit || (st_r == tsp_pkg::ST_IO2 && deny)) begin
        exc_vld_r <= 1'b1;
        exc_vec_r <= tsp_pkg::VEC_GP;
      end else if (esc_flt) begin
        exc_vld_r <= 1'b1;
        exc_vec_r <= tsp_pkg::VEC_NOCOP;
      end else if (st_r == tsp_pkg::ST_FIN && tbit) begin
        exc_vld_r <= 1'b1;
        exc_vec_r <= tsp_pkg::VEC_DEBUG;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_r <= tsp_pkg::RST_ZERO;
      io_done_r <= 1'b0;
      io_ok_r <= 1'b0;
    end else begin
      if (io_go) begin
        io_r <= hwdata;
        io_done_r <= io_priv;
        io_ok_r <= io_priv;
      end else if (st_r == tsp_pkg::ST_IO2) begin
        io_done_r <= 1'b1;
        io_ok_r <= !deny;
      end
    end
  end

  assign stat = {16'h0000, exc_vec_r, mark_r, io_ok_r, io_done_r, busy, exc_vld_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= tsp_pkg::RST_ZERO;
    end else if (a_vld_r && !a_wr_r && !mdone_r) begin
      case (a_addr_r)
        tsp_pkg::OFF_OP: rd_r <= op_r;
        tsp_pkg::OFF_FLG: rd_r <= flags_r;
        tsp_pkg::OFF_CR0: rd_r <= cr0_r;
        tsp_pkg::OFF_TR: rd_r <= {16'h0000, tr_r};
        tsp_pkg::OFF_DESC: rd_r <= desc_r;
        tsp_pkg::OFF_HID: rd_r <= {limit_r, base_r};
        tsp_pkg::OFF_IO: rd_r <= io_r;
        tsp_pkg::OFF_STAT: rd_r <= stat;
        tsp_pkg::OFF_CTX: rd_r <= ctx_r;
        default: rd_r <= tsp_pkg::RST_ZERO;
      endcase
    end
  end

  chk_switch_len: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_go |=> ##8 st_r == tsp_pkg::ST_FIN) else $error("switch did not finish in time");
  chk_ts_set: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == tsp_pkg::ST_FIN |=> ts) else $error("task switched flag not set");
  chk_busy_fault: assert property (@(posedge hclk) disable iff (!hresetn)
    busy_hit |=> exc_vld_r && exc_vec_r == tsp_pkg::VEC_GP && !busy)
    else $error("busy target not faulted");
  chk_cop_fault: assert property (@(posedge hclk) disable iff (!hresetn)
    esc_flt |=> exc_vld_r && exc_vec_r == tsp_pkg::VEC_NOCOP)
    else $error("coprocessor op after switch not faulted");
  chk_io_fast: assert property (@(posedge hclk) disable iff (!hresetn)
    io_go && io_priv |=> io_done_r && io_ok_r && !busy) else $error("privileged io held");
  chk_io_deny: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == tsp_pkg::ST_IO2 && deny |=> !io_ok_r && exc_vec_r == tsp_pkg::VEC_GP)
    else $error("denied io not faulted");
  chk_nested_set: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == tsp_pkg::ST_FIN && op_link |=> nt && tr_r == $past(nsel_r))
    else $error("nested flag or selector wrong after switch");
  chk_int_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    int_plain |=> !nt) else $error("nested flag not cleared");
  chk_tr_load: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_at(tsp_pkg::OFF_TR, a_vld_r, a_wr_r, a_addr_r) && !a_mem && !busy
    |=> base_r == $past(desc_r[15:0]) && limit_r == $past(desc_r[31:16]))
    else $error("hidden base or limit not loaded");
  chk_interrupt_return_op_plain: assert property (@(posedge hclk) disable iff (!hresetn)
    op_go && hwdata[2:0] == tsp_pkg::OPC_INTERRUPT_RETURN_OP |=> busy == $past(nt))
    else $error("return path wrong for nested flag");

  cov_call_switch: cover property (@(posedge hclk) disable iff (!hresetn)
    sw_go && hwdata[2:0] == tsp_pkg::OPC_CALL ##10 st_r == tsp_pkg::ST_IDLE);
  cov_io_denied: cover property (@(posedge hclk) disable iff (!hresetn)
    st_r == tsp_pkg::ST_IO2 && deny);
  cov_cop_fault: cover property (@(posedge hclk) disable iff (!hresetn) esc_flt);
endmodule

/* File: tsp_core_tb.sv */
`timescale 1ns/10ps
module tsp_core_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int error_cnt = 0;
  int tests_run = 0;

  always #5 hclk = ~hclk;

  tsp_core i_tsp_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );

  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Entered just after a rising edge; returns just after the edge where hready was high
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        error_cnt++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {23'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string n, input logic [8:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(n, rd & m, e);
  endtask

  // Busy only drops once the engine is back in idle; bounded poll
  task automatic idle();
    int n;
    n = 0;
    bus(1'b0, tsp_pkg::OFF_STAT, 32'h0000_0000, rd);
    while (rd[1] !== 1'b0) begin
      n++;
      if (n > 64) begin
        error_cnt++;
        conclude();
      end
      bus(1'b0, tsp_pkg::OFF_STAT, 32'h0000_0000, rd);
    end
  endtask

  task automatic cmd(input logic [8:0] a, input logic [31:0] d);
    wr(tsp_pkg::OFF_STAT, 32'h0000_0001);
    wr(a, d);
    idle();
  endtask

  task automatic t_sel();
    rdc("status_rst", tsp_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0090);
    wr(tsp_pkg::OFF_DESC, 32'h007F_0000);
    wr(tsp_pkg::OFF_TR, 32'h0000_0010);
    rdc("hidden", tsp_pkg::OFF_HID, 32'hFFFF_FFFF, 32'h007F_0000);
    // Descriptor change alone must not reach the hidden copy
    wr(tsp_pkg::OFF_DESC, 32'h007F_0080);
    wr(9'h030, 32'hFFFF_FFFF);
    rdc("hidden_keep", tsp_pkg::OFF_HID, 32'hFFFF_FFFF, 32'h007F_0000);
    rdc("unmapped", 9'h030, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask

  task automatic t_io();
    logic [31:0] row [8];
    row = '{32'h000C_0029, 32'h010C_0028, 32'h000E_0026, 32'h010E_0024,
            32'h000C_0400, 32'h0124_0029, 32'h0128_0029, 32'h002C_0029};
    // Block at 0: map base 0x20, port 41 and ports 96 to 127 denied inside the map
    wr(9'h10C, 32'h0000_0020);
    wr(9'h120, 32'h0000_0000);
    wr(9'h124, 32'h0000_0200);
    wr(9'h128, 32'h0000_0000);
    wr(9'h12C, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      wr(tsp_pkg::OFF_FLG, {17'h00000, row[i][21:20], 13'h0000});
      cmd(tsp_pkg::OFF_IO, {12'h000, row[i][19:0]});
      rdc("io", tsp_pkg::OFF_STAT, row[i][24] ? 32'h0000_000D : 32'h0000_FF0D,
          row[i][24] ? 32'h0000_000C : 32'h0000_0D05);
    end
  endtask

  task automatic t_call();
    wr(9'h184, 32'h0000_0000);
    wr(9'h188, 32'hCAFE_0001);
    wr(9'h18C, 32'h0001_0040);
    wr(9'h1C4, 32'h0000_0000);
    wr(9'h1C8, 32'hFFFF_FFFF);
    wr(tsp_pkg::OFF_FLG, 32'h0000_0000);
    wr(tsp_pkg::OFF_CTX, 32'h1234_5678);
    cmd(tsp_pkg::OFF_OP, 32'h0028_009A);
    rdc("tr_call", tsp_pkg::OFF_TR, 32'h0000_FFFF, 32'h0000_0028);
    rdc("ctx_saved", 9'h108, 32'hFFFF_FFFF, 32'h1234_5678);
    rdc("ctx_loaded", tsp_pkg::OFF_CTX, 32'hFFFF_FFFF, 32'hCAFE_0001);
    rdc("back_link", 9'h180, 32'h0000_FFFF, 32'h0000_0010);
    rdc("nested", tsp_pkg::OFF_FLG, 32'h0000_8000, 32'h0000_8000);
    rdc("ts_call", tsp_pkg::OFF_CR0, 32'h0000_0008, 32'h0000_0008);
    rdc("st_call", tsp_pkg::OFF_STAT, 32'h0000_FFF1, 32'h0000_01B1);
    // Same port as the denied one, but the new block's own map allows it
    cmd(tsp_pkg::OFF_IO, 32'h000C_0029);
    rdc("io_own_map", tsp_pkg::OFF_STAT, 32'h0000_000D, 32'h0000_000C);
  endtask

  task automatic t_cop();
    cmd(tsp_pkg::OFF_OP, 32'h0000_0005);
    rdc("esc_first", tsp_pkg::OFF_STAT, 32'h0000_FF01, 32'h0000_0701);
    rdc("ctx_esc", tsp_pkg::OFF_CTX, 32'hFFFF_FFFF, 32'hCAFE_0001);
    wr(tsp_pkg::OFF_CR0, 32'h0000_0000);
    cmd(tsp_pkg::OFF_OP, 32'h0000_0005);
    rdc("esc_again", tsp_pkg::OFF_STAT, 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic t_busy();
    cmd(tsp_pkg::OFF_OP, 32'h0030_00BA);
    rdc("busy_fault", tsp_pkg::OFF_STAT, 32'h0000_FF01, 32'h0000_0D01);
    rdc("tr_busy", tsp_pkg::OFF_TR, 32'h0000_FFFF, 32'h0000_0028);
  endtask

  task automatic t_ret();
    wr(tsp_pkg::OFF_DESC, 32'h007F_0000);
    cmd(tsp_pkg::OFF_OP, 32'h0000_0004);
    rdc("tr_ret", tsp_pkg::OFF_TR, 32'h0000_FFFF, 32'h0000_0010);
    rdc("ctx_ret", tsp_pkg::OFF_CTX, 32'hFFFF_FFFF, 32'h1234_5678);
    rdc("nt_ret", tsp_pkg::OFF_FLG, 32'h0000_8000, 32'h0000_0000);
  endtask

  task automatic t_jmp();
    wr(tsp_pkg::OFF_CR0, 32'h0000_0000);
    wr(tsp_pkg::OFF_DESC, 32'h007F_0080);
    cmd(tsp_pkg::OFF_OP, 32'h0028_0099);
    rdc("tr_jmp", tsp_pkg::OFF_TR, 32'h0000_FFFF, 32'h0000_0028);
    rdc("ts_jmp", tsp_pkg::OFF_CR0, 32'h0000_0008, 32'h0000_0008);
    rdc("nt_jmp", tsp_pkg::OFF_FLG, 32'h0000_8000, 32'h0000_8000);
    rdc("type_jmp", tsp_pkg::OFF_STAT, 32'h0000_00F0, 32'h0000_00B0);
  endtask

  task automatic t_nest();
    wr(tsp_pkg::OFF_FLG, 32'h0000_8000);
    cmd(tsp_pkg::OFF_OP, 32'h0000_0003);
    rdc("nt_int", tsp_pkg::OFF_FLG, 32'h0000_8000, 32'h0000_0000);
    cmd(tsp_pkg::OFF_OP, 32'h0000_0004);
    rdc("nt_back", tsp_pkg::OFF_FLG, 32'h0000_8000, 32'h0000_8000);
    rdc("tr_plain", tsp_pkg::OFF_TR, 32'h0000_FFFF, 32'h0000_0028);
  endtask

  task automatic t_gate();
    wr(tsp_pkg::OFF_FLG, 32'h0000_0000);
    wr(tsp_pkg::OFF_DESC, 32'h007F_0000);
    cmd(tsp_pkg::OFF_OP, 32'h0010_009B);
    rdc("tr_gate", tsp_pkg::OFF_TR, 32'h0000_FFFF, 32'h0000_0010);
    rdc("link_gate", 9'h100, 32'h0000_FFFF, 32'h0000_0028);
    rdc("nt_gate", tsp_pkg::OFF_FLG, 32'h0000_8000, 32'h0000_8000);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_sel();
    t_io();
    t_call();
    t_cop();
    t_busy();
    t_ret();
    t_jmp();
    t_nest();
    t_gate();
    conclude();
  end
endmodule

/* File: tsp_mem.sv */
`timescale 1ns/10ps
module tsp_mem (
  input wire logic hclk,
  input wire logic [tsp_pkg::MEM_AW-1:0] addr,
  input wire logic we,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata_r
);
  logic [31:0] mem [0:(1<<tsp_pkg::MEM_AW)-1];

  // No reset: contents are software-built task blocks
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_r <= mem[addr];
  end
endmodule

/* File: tsp_pkg.sv */
// Contract
// - Far jump or call naming a task block or task gate switches tasks.
// - Interrupt or exception whose table entry is a task gate switches tasks.
// - A switch saves outgoing state, loads incoming state, checks, then runs.
// - Writing the task selector loads hidden base and limit from its descriptor.
// - Interrupt return: plain return if nested flag 0, switch back if 1.
// - Call or interrupt switch marks busy, writes back-link, sets nested flag.
// - Interrupt without switch clears nested flag; return restores it.
// - Busy marking turns type 9 into 0xB; using a busy block raises 13.
// - Every task switch sets the task switched flag in control word zero.
// - First coprocessor instruction after a switch raises exception 7.
// - Coprocessor state is never saved or restored by a switch.
// - Debug trap bit set in incoming block raises exception 1 on entry.
// - Port access proceeds at privilege at or above threshold, else map check.
// - A 16-bit map base field in the task block locates the map.
// - Map byte is base plus port div 8; bit is port mod 8.
// - All bits spanned by the access are tested; any set raises 13.
// - Ports beyond the end of the map behave as set bits.
// - The privilege threshold sits in bits 13 and 14 of the flags word.
package tsp_pkg;
  localparam logic [8:0] OFF_OP = 9'h000;
  localparam logic [8:0] OFF_FLG = 9'h004;
  localparam logic [8:0] OFF_CR0 = 9'h008;
  localparam logic [8:0] OFF_TR = 9'h00C;
  localparam logic [8:0] OFF_DESC = 9'h010;
  localparam logic [8:0] OFF_HID = 9'h014;
  localparam logic [8:0] OFF_IO = 9'h018;
  localparam logic [8:0] OFF_STAT = 9'h01C;
  localparam logic [8:0] OFF_CTX = 9'h020;
  localparam int MEM_BIT = 8;
  localparam int MEM_AW = 6;
  // Layout inside a task block, byte offsets
  localparam logic [16:0] TSB_LINK = 17'h00000;
  localparam logic [16:0] TSB_FLG = 17'h00004;
  localparam logic [16:0] TSB_CTX = 17'h00008;
  localparam logic [16:0] TSB_MAP = 17'h0000C;
  localparam int TSB_TBIT = 16;
  localparam int FLG_IO_PRIVILEGE_THRESHOLD_LO = 13;
  localparam int FLG_NT = 15;
  localparam int CR0_TS = 3;
  localparam logic [2:0] OPC_JMP = 3'h1;
  localparam logic [2:0] OPC_CALL = 3'h2;
  localparam logic [2:0] OPC_INT = 3'h3;
  localparam logic [2:0] OPC_INTERRUPT_RETURN_OP = 3'h4;
  localparam logic [2:0] OPC_ESC = 3'h5;
  localparam logic [3:0] TYPE_AVAIL = 4'h9;
  localparam logic [3:0] TYPE_BUSY = 4'hB;
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_NOCOP = 8'h07;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_SV_FLG = 4'h1, ST_SV_CTX = 4'h3, ST_RD_LINK = 4'h2,
    ST_WR_LINK = 4'h6, ST_LD_FLG = 4'h7, ST_LD_CTX = 4'h5, ST_LD_MAP = 4'h4,
    ST_LD_WAIT = 4'hC, ST_FIN = 4'hD, ST_IOM = 4'h8, ST_IOB = 4'h9,
    ST_IO0 = 4'hB, ST_IO1 = 4'hA, ST_IO2 = 4'hE
  } tsp_state_t;
endpackage
